// ---- hdl/mcp_pwm_regs.vh ----
// register indices, field positions and reset values of the motor pwm block
// assumes a 16-bit register port with a 4-bit word address
`ifndef MCP_PWM_REGS_VH
`define MCP_PWM_REGS_VH
`define MCP_ADDR_TBCON     4'h0
`define MCP_ADDR_TBCOUNT   4'h1
`define MCP_ADDR_TBPER     4'h2
`define MCP_ADDR_SECMP     4'h3
`define MCP_ADDR_PAIRCON   4'h4
`define MCP_ADDR_UPDCON    4'h5
`define MCP_ADDR_DTCON     4'h6
`define MCP_ADDR_DTSEL     4'h7
`define MCP_ADDR_OVRD      4'h8
`define MCP_ADDR_DUTY0     4'h9
`define MCP_ADDR_STATUS    4'hC
// timebase_control fields
`define MCP_TB_ON          15
`define MCP_TB_IDLE        13
`define MCP_TB_OPS_HI      7
`define MCP_TB_OPS_LO      4
`define MCP_TB_CKPS_HI     3
`define MCP_TB_CKPS_LO     2
`define MCP_TB_MODE_HI     1
`define MCP_TB_MODE_LO     0
`define MCP_TBCON_MASK     16'hA0FF
// output_pair_control and override fields
`define MCP_PAIR_MODE_LO   8
`define MCP_PAIR_ENH_LO    4
`define MCP_PAIR_ENL_LO    0
`define MCP_OVRD_EN_LO     8
`define MCP_OVRD_VAL_LO    0
// update_control fields
`define MCP_UPD_OPS_HI     11
`define MCP_UPD_OPS_LO     8
`define MCP_UPD_IUE        2
`define MCP_UPD_OVERRIDE_SYNC      1
`define MCP_UPD_BUFFER_UPDATE_DISABLE       0
`define MCP_UPDCON_MASK    16'h0F07
// dead_time_control fields
`define MCP_DTB_PS_HI      15
`define MCP_DTB_PS_LO      14
`define MCP_DTB_HI         13
`define MCP_DTB_LO         8
`define MCP_DTA_PS_HI      7
`define MCP_DTA_PS_LO      6
`define MCP_DTA_HI         5
`define MCP_DTA_LO         0
// count modes
`define MCP_MODE_FREE      2'h0
`define MCP_MODE_SINGLE    2'h1
`define MCP_MODE_UPDN      2'h2
`define MCP_MODE_UPDN_DBL  2'h3
`define MCP_ZERO15         15'h0000
`define MCP_ZERO16         16'h0000
`endif

// ---- hdl/mcp_pwm.v ----
// motor control pwm: 15-bit time base, special event trigger, duty pairs, dead time
// assumes a single clock mclk equal to the instruction cycle, synchronous reset rst,
// a simple register port and pins pairOutH/L driven through output enables
//
// Overview of operation
// - timebase_on starts and stops counting
// - idle stop halts time base in idle
// - output postscale divides period events by n+1
// - input prescale gives 1,4,16,64 cycle ticks
// - mode selects free, single, up/down, up/down double
// - count bit 15 reads direction, read-only
// - count bits 14-0 readable and writable
// - period is 15 bits, bit 15 reads zero
// - trigger when compare value equals count
// - trigger also needs direction match
// - trigger postscale passes one of n+1
// - pair mode bit selects independent or complementary
// - complementary low output is inverse of high
// - enable bits give pins to modulator
// - enable reset value from configuration strap
// - immediate duty update or time base synced
// - override sync to time base or next cycle
// - update disable freezes buffer transfers
// - dead-time B prescale 1,2,4,8 cycles
// - dead-time B delay is value times period
// - dead-time A has own prescale and value
// - pair count parameter, three or one pairs
// - sixteen-bit writable duty value per pair
// - select bits choose dead-time unit per edge
`include "mcp_pwm_regs.vh"
module mcp_pwm #(
  parameter NPAIR = 3
) (
  // clock and reset
  input  wire              mclk,
  input  wire              rst,
  // system state and configuration
  input  wire              cpuIdle,
  input  wire              outEnableResetCfg,
  // register port
  input  wire [3:0]        regAddr,
  input  wire [15:0]       regWrData,
  input  wire              regWr,
  input  wire              regRd,
  output reg  [15:0]       regRdData,
  // pins and trigger
  output reg  [NPAIR-1:0]  pairOutH,
  output reg  [NPAIR-1:0]  pairOutL,
  output reg  [NPAIR-1:0]  pairOeH,
  output reg  [NPAIR-1:0]  pairOeL,
  output reg               specialEventTrig
);

  // control registers
  reg  [15:0]       tbCon_q;
  reg  [14:0]       tbCount_q;
  reg               tbDown_q;
  reg  [14:0]       tbPerBuf_q;
  reg  [14:0]       tbPer_q;
  reg  [15:0]       seCmp_q;
  reg  [NPAIR-1:0]  pairMode_q;
  reg  [NPAIR-1:0]  enH_q;
  reg  [NPAIR-1:0]  enL_q;
  reg  [15:0]       updCon_q;
  reg  [15:0]       dtCon_q;
  reg  [2*NPAIR-1:0] dtSel_q;
  reg  [2*NPAIR-1:0] ovrdEn_q;
  reg  [2*NPAIR-1:0] ovrdVal_q;
  reg  [2*NPAIR-1:0] ovrdAct_q;
  reg  [16*NPAIR-1:0] dutyBuf_q;
  reg  [16*NPAIR-1:0] duty_q;
  reg  [5:0]        preCnt_q;
  reg  [3:0]        opsCnt_q;
  reg  [3:0]        seCnt_q;
  reg               periodEvt_q;
  reg               strapDone_q;
  reg  [2:0]        idleSync_q;
  reg               idleSt_q;

  // prescale period minus one for the 2-bit codes of the time base
  function [5:0] tbPreMax;
    input [1:0] code;
    begin
      case (code)
        2'h0:    tbPreMax = 6'h00;
        2'h1:    tbPreMax = 6'h03;
        2'h2:    tbPreMax = 6'h0F;
        default: tbPreMax = 6'h3F;
      endcase
    end
  endfunction

  // dead-time length in cycles: value shifted by prescale code (1,2,4,8 cycles)
  function [8:0] dtLen;
    input [1:0] ps;
    input [5:0] val;
    begin
      dtLen = {3'h0, val} << ps;
    end
  endfunction

  wire [1:0] tbMode   = tbCon_q[`MCP_TB_MODE_HI:`MCP_TB_MODE_LO];
  wire       updnMode = tbMode[1];
  wire [8:0] dtLenA   = dtLen(dtCon_q[`MCP_DTA_PS_HI:`MCP_DTA_PS_LO],
                              dtCon_q[`MCP_DTA_HI:`MCP_DTA_LO]);
  wire [8:0] dtLenB   = dtLen(dtCon_q[`MCP_DTB_PS_HI:`MCP_DTB_PS_LO],
                              dtCon_q[`MCP_DTB_HI:`MCP_DTB_LO]);

  // idle input comes from another domain: three flops, change seen when 2 and 3 agree
  always @(posedge mclk) begin
    if (rst) begin
      idleSync_q <= 3'h0;
      idleSt_q   <= 1'b0;
    end else begin
      idleSync_q <= {idleSync_q[1:0], cpuIdle};
      if (idleSync_q[1] == idleSync_q[2])
        idleSt_q <= idleSync_q[2];
    end
  end

  wire tbRun = tbCon_q[`MCP_TB_ON]
             & ~(tbCon_q[`MCP_TB_IDLE] & idleSt_q);
  wire tick  = tbRun & (preCnt_q == tbPreMax(tbCon_q[`MCP_TB_CKPS_HI:`MCP_TB_CKPS_LO]));
  wire atPer = (tbCount_q >= tbPer_q);
  wire atZero = (tbCount_q == `MCP_ZERO15);
  // period boundary: free/single at period, up/down at zero
  wire boundary = tick & (updnMode ? (tbDown_q & atZero) : atPer);
  // double-update mode also lets buffers move at the period apex
  wire updPoint = boundary | (tick & (tbMode == `MCP_MODE_UPDN_DBL) & ~tbDown_q & atPer);
  wire wrSel = regWr;

  // time base counter, direction and prescaler
  always @(posedge mclk) begin
    if (rst) begin
      tbCount_q <= `MCP_ZERO15;
      tbDown_q  <= 1'b0;
      preCnt_q  <= 6'h00;
    end else begin
      preCnt_q <= tick | ~tbRun ? 6'h00 : preCnt_q + 6'h01;
      if (wrSel && regAddr == `MCP_ADDR_TBCOUNT) begin
        tbCount_q <= regWrData[14:0];
      end else if (tick) begin
        if (updnMode) begin
          if (!tbDown_q && atPer) begin
            tbDown_q  <= 1'b1;
            tbCount_q <= tbCount_q - 15'h0001;
          end else if (tbDown_q && atZero) begin
            tbDown_q  <= 1'b0;
            tbCount_q <= tbCount_q + 15'h0001;
          end else begin
            tbCount_q <= tbDown_q ? tbCount_q - 15'h0001 : tbCount_q + 15'h0001;
          end
        end else begin
          tbDown_q  <= 1'b0;
          tbCount_q <= atPer ? `MCP_ZERO15 : tbCount_q + 15'h0001;
        end
      end
    end
  end

  // output postscaler; cleared while stopped so a new postscale starts from a fresh count
  always @(posedge mclk) begin
    if (rst || !tbCon_q[`MCP_TB_ON]) begin
      opsCnt_q    <= 4'h0;
      periodEvt_q <= 1'b0;
    end else begin
      periodEvt_q <= 1'b0;
      if (boundary) begin
        if (opsCnt_q == tbCon_q[`MCP_TB_OPS_HI:`MCP_TB_OPS_LO]) begin
          opsCnt_q    <= 4'h0;
          periodEvt_q <= 1'b1;
        end else begin
          opsCnt_q <= opsCnt_q + 4'h1;
        end
      end
    end
  end

  // special event: match of count and direction, then its own postscaler
  wire seMatch = tick & (seCmp_q[14:0] == tbCount_q)
               & (seCmp_q[15] == tbDown_q);
  // a stale count above a newly lowered postscale would swallow up to 15 matches
  always @(posedge mclk) begin
    if (rst || !tbCon_q[`MCP_TB_ON]) begin
      seCnt_q          <= 4'h0;
      specialEventTrig <= 1'b0;
    end else begin
      specialEventTrig <= 1'b0;
      if (seMatch) begin
        if (seCnt_q == updCon_q[`MCP_UPD_OPS_HI:`MCP_UPD_OPS_LO]) begin
          seCnt_q          <= 4'h0;
          specialEventTrig <= 1'b1;
        end else begin
          seCnt_q <= seCnt_q + 4'h1;
        end
      end
    end
  end

  // register writes; single pulse mode clears the enable at the end of its period
  integer k;
  always @(posedge mclk) begin
    if (rst) begin
      tbCon_q    <= `MCP_ZERO16;
      tbPerBuf_q <= `MCP_ZERO15;
      tbPer_q    <= `MCP_ZERO15;
      seCmp_q    <= `MCP_ZERO16;
      pairMode_q <= {NPAIR{1'b0}};
      updCon_q   <= `MCP_ZERO16;
      dtCon_q    <= `MCP_ZERO16;
      dtSel_q    <= {2*NPAIR{1'b0}};
      ovrdEn_q   <= {2*NPAIR{1'b1}};
      ovrdVal_q  <= {2*NPAIR{1'b0}};
      dutyBuf_q  <= {16*NPAIR{1'b0}};
      duty_q     <= {16*NPAIR{1'b0}};
    end else begin
      if (wrSel) begin
        case (regAddr)
          `MCP_ADDR_TBCON:   tbCon_q    <= regWrData & `MCP_TBCON_MASK;
          `MCP_ADDR_TBPER:   tbPerBuf_q <= regWrData[14:0];
          `MCP_ADDR_SECMP:   seCmp_q    <= regWrData;
          `MCP_ADDR_PAIRCON: pairMode_q <= regWrData[`MCP_PAIR_MODE_LO +: NPAIR];
          `MCP_ADDR_UPDCON:  updCon_q   <= regWrData & `MCP_UPDCON_MASK;
          `MCP_ADDR_DTCON:   dtCon_q    <= regWrData;
          `MCP_ADDR_DTSEL:   dtSel_q    <= regWrData[2*NPAIR-1:0];
          `MCP_ADDR_OVRD: begin
            ovrdEn_q  <= regWrData[`MCP_OVRD_EN_LO +: 2*NPAIR];
            ovrdVal_q <= regWrData[`MCP_OVRD_VAL_LO +: 2*NPAIR];
          end
          default: ;
        endcase
        for (k = 0; k < NPAIR; k = k + 1)
          if (regAddr == `MCP_ADDR_DUTY0 + k[3:0])
            dutyBuf_q[16*k +: 16] <= regWrData;
      end
      if (tbMode == `MCP_MODE_SINGLE && boundary)
        tbCon_q[`MCP_TB_ON] <= 1'b0;
      // buffer transfer: duty immediate or at update point, period at update point or while the time base is off
      if (!updCon_q[`MCP_UPD_BUFFER_UPDATE_DISABLE]) begin
        if (updCon_q[`MCP_UPD_IUE] || updPoint)
          duty_q <= dutyBuf_q;
        if (updPoint || !tbCon_q[`MCP_TB_ON])
          tbPer_q <= tbPerBuf_q;
      end
    end
  end

  // enables reset to the strap; caught one cycle after reset release by a clocked load
  always @(posedge mclk) begin
    if (rst) begin
      enH_q       <= {NPAIR{1'b0}};
      enL_q       <= {NPAIR{1'b0}};
      strapDone_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      enH_q       <= {NPAIR{outEnableResetCfg}};
      enL_q       <= {NPAIR{outEnableResetCfg}};
    end else if (wrSel && regAddr == `MCP_ADDR_PAIRCON) begin
      enH_q <= regWrData[`MCP_PAIR_ENH_LO +: NPAIR];
      enL_q <= regWrData[`MCP_PAIR_ENL_LO +: NPAIR];
    end
  end

  // override enables apply on the next cycle, or at the period boundary when synced
  always @(posedge mclk) begin
    if (rst)
      ovrdAct_q <= {2*NPAIR{1'b1}};
    else if (!updCon_q[`MCP_UPD_OVERRIDE_SYNC] || boundary)
      ovrdAct_q <= ovrdEn_q;
  end

  // duty compare and dead time per pair; count compared as 16 bits so 0xFFFF stays on
  genvar g;
  generate
    for (g = 0; g < NPAIR; g = g + 1) begin : gPair
      reg  [8:0] dtCnt_q;
      reg        rawPrev_q;
      reg        hi_q;
      reg        lo_q;
      wire       raw  = {1'b0, tbCount_q} < duty_q[16*g +: 16];
      wire [8:0] lenA = dtSel_q[2*g+1] ? dtLenB : dtLenA;
      wire [8:0] lenI = dtSel_q[2*g]   ? dtLenB : dtLenA;
      always @(posedge mclk) begin
        if (rst) begin
          dtCnt_q   <= 9'h000;
          rawPrev_q <= 1'b0;
          hi_q      <= 1'b0;
          lo_q      <= 1'b0;
        end else begin
          rawPrev_q <= raw;
          if (pairMode_q[g]) begin
            hi_q    <= raw;
            lo_q    <= raw;
            dtCnt_q <= 9'h000;
          end else if (raw != rawPrev_q) begin
            // both off during dead time; a zero length switches at once
            hi_q    <= raw & (lenA == 9'h000);
            lo_q    <= ~raw & (lenI == 9'h000);
            dtCnt_q <= raw ? lenA : lenI;
          end else if (dtCnt_q > 9'h001) begin
            dtCnt_q <= dtCnt_q - 9'h001;
          end else begin
            dtCnt_q <= 9'h000;
            hi_q    <= raw;
            lo_q    <= ~raw;
          end
        end
      end
      // pins: overrides take the pin, enable hands it to the modulator
      always @(posedge mclk) begin
        if (rst) begin
          pairOutH[g] <= 1'b0;
          pairOutL[g] <= 1'b0;
          pairOeH[g]  <= 1'b0;
          pairOeL[g]  <= 1'b0;
        end else begin
          pairOutH[g] <= ovrdAct_q[2*g+1] ? hi_q : ovrdVal_q[2*g+1];
          pairOutL[g] <= ovrdAct_q[2*g]   ? lo_q : ovrdVal_q[2*g];
          pairOeH[g]  <= enH_q[g];
          pairOeL[g]  <= enL_q[g];
        end
      end
    end
  endgenerate

  // read data, one cycle after the strobe; unmapped addresses read zero
  reg [15:0] rdMux;
  integer j;
  always @* begin
    rdMux = `MCP_ZERO16;
    case (regAddr)
      `MCP_ADDR_TBCON:   rdMux = tbCon_q;
      `MCP_ADDR_TBCOUNT: rdMux = {tbDown_q, tbCount_q};
      `MCP_ADDR_TBPER:   rdMux = {1'b0, tbPerBuf_q};
      `MCP_ADDR_SECMP:   rdMux = seCmp_q;
      `MCP_ADDR_PAIRCON: begin
        rdMux[`MCP_PAIR_MODE_LO +: NPAIR] = pairMode_q;
        rdMux[`MCP_PAIR_ENH_LO +: NPAIR]  = enH_q;
        rdMux[`MCP_PAIR_ENL_LO +: NPAIR]  = enL_q;
      end
      `MCP_ADDR_UPDCON:  rdMux = updCon_q;
      `MCP_ADDR_DTCON:   rdMux = dtCon_q;
      `MCP_ADDR_DTSEL:   rdMux[2*NPAIR-1:0] = dtSel_q;
      `MCP_ADDR_OVRD: begin
        rdMux[`MCP_OVRD_EN_LO +: 2*NPAIR]  = ovrdEn_q;
        rdMux[`MCP_OVRD_VAL_LO +: 2*NPAIR] = ovrdVal_q;
      end
      `MCP_ADDR_STATUS:  rdMux = {14'h0000, periodEvt_q, tbRun};
      default:           rdMux = `MCP_ZERO16;
    endcase
    for (j = 0; j < NPAIR; j = j + 1)
      if (regAddr == `MCP_ADDR_DUTY0 + j[3:0])
        rdMux = dutyBuf_q[16*j +: 16];
  end

  always @(posedge mclk) begin
    if (rst)
      regRdData <= `MCP_ZERO16;
    else
      regRdData <= regRd ? rdMux : `MCP_ZERO16;
  end

endmodule // mcp_pwm

// ---- tb/mcp_pwm_chk.sv ----
// checker of the motor pwm block: read port, pin ownership, trigger and pair rules
// sees only the block's ports; shadows two control registers from observed writes
module mcp_pwm_chk #(
  parameter NPAIR = 3
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // configuration
  input wire logic             cpuIdle,
  input wire logic             outEnableResetCfg,
  // register port
  input wire logic [3:0]       regAddr,
  input wire logic [15:0]      regWrData,
  input wire logic             regWr,
  input wire logic             regRd,
  input wire logic [15:0]      regRdData,
  // pins and trigger
  input wire logic [NPAIR-1:0] pairOutH,
  input wire logic [NPAIR-1:0] pairOutL,
  input wire logic [NPAIR-1:0] pairOeH,
  input wire logic [NPAIR-1:0] pairOeL,
  input wire logic             specialEventTrig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pairCon_q;
  logic [15:0] tbCon_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // shadows; hardware may only clear the on bit, so a shadowed off is reliable
  always_ff @(posedge mclk) begin
    if (rst) begin
      pairCon_q <= 16'h0000;
      tbCon_q   <= 16'h0000;
    end else if (regWr && regAddr == 4'h4) begin
      pairCon_q <= regWrData;
    end else if (regWr && regAddr == 4'h0) begin
      tbCon_q <= regWrData;
    end
  end
  sequence s_pair_write;
    (regWr && regAddr == 4'h4) ##1 !(regWr && regAddr == 4'h4);
  endsequence
  property p_oe_follow;
    s_pair_write |=> pairOeH == pairCon_q[4 +: NPAIR] && pairOeL == pairCon_q[0 +: NPAIR];
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("enables differ");
  property p_oe_strap;
    $fell(rst) |-> ##[1:2] (pairOeH == {NPAIR{outEnableResetCfg}});
  endproperty
  a_oe_strap: assert property (p_oe_strap) else $error("enables not strapped");
  property p_rd_idle;
    !regRd |=> regRdData == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_per_top;
    regRd && regAddr == 4'h2 |=> !regRdData[15];
  endproperty
  a_per_top: assert property (p_per_top) else $error("period top bit set");
  property p_unmapped;
    regRd && regAddr == 4'hF |=> regRdData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_trig_pulse;
    specialEventTrig |=> !specialEventTrig;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  property p_trig_off;
    (!tbCon_q[15]) [*3] |-> !specialEventTrig;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger while stopped");
  property p_no_shoot;
    (!pairCon_q[8]) [*3] ##0 (pairOeH[0] && pairOeL[0]) |-> !(pairOutH[0] && pairOutL[0]);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("pair both active");
endmodule // mcp_pwm_chk

// ---- tb/mcp_switch_model.sv ----
// switch pair model: tallies conduction of pair 0 and trigger pulses per window
// assumes the pwm pins; a switch conducts only while its pin enable is high
module mcp_switch_model #(
  parameter int NPAIR = 3
) (
  // clock and window restart
  input  wire logic             mclk,
  input  wire logic             clr,
  // pins from the pwm block
  input  wire logic [NPAIR-1:0] pairOutH,
  input  wire logic [NPAIR-1:0] pairOutL,
  input  wire logic [NPAIR-1:0] pairOeH,
  input  wire logic [NPAIR-1:0] pairOeL,
  input  wire logic             specialEventTrig,
  // tallies
  output var  int               hiCnt,
  output var  int               loCnt,
  output var  int               bothCnt,
  output var  int               trigCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hiOn;
  logic loOn;
  assign hiOn = pairOutH[0] & pairOeH[0];
  assign loOn = pairOutL[0] & pairOeL[0];
  // both switches on at once shorts the supply leg, so overlap is tallied apart
  always @(posedge mclk) begin
    if (clr) begin
      hiCnt <= 0;
      loCnt <= 0;
      bothCnt <= 0;
      trigCnt <= 0;
    end else begin
      hiCnt <= hiCnt + int'(hiOn);
      loCnt <= loCnt + int'(loOn);
      bothCnt <= bothCnt + int'(hiOn & loOn);
      trigCnt <= trigCnt + int'(specialEventTrig);
    end
  end
endmodule // mcp_switch_model

// ---- tb/mcp_pwm_tb_top.sv ----
// testbench of the motor pwm block: register tasks, timed windows and pin tallies
// assumes three pairs, a bench-driven strap, and the switch model on the pins
module mcp_pwm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPAIR = 3;
  localparam logic [3:0] RA [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  localparam logic [3:0] MA [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  localparam logic [15:0] ME [5] = '{16'h7FFF, 16'h7FFF, 16'hFFFF, 16'h0F07, 16'hFFFF};
  localparam logic [15:0] PC [6] = '{16'h8000, 16'h8004, 16'h8008, 16'h800C, 16'hA000,
    16'h8000};
  localparam int PE [6] = '{256, 64, 16, 4, 0, 256};
  localparam logic [15:0] TS [5] = '{16'h0005, 16'h8005, 16'h0005, 16'h0005, 16'h8005};
  localparam logic [15:0] TU [5] = '{16'h0000, 16'h0000, 16'h0300, 16'h0F00, 16'h0000};
  localparam int TE [5] = '{20, 0, 5, 1, 10};
  localparam logic [15:0] PD [3] = '{16'h0002, 16'h4100, 16'h0000};
  localparam int ES [3] = '{120, 120, 200};
  logic             mclk, rst, cpuIdle, clr, regWr, regRd, specialEventTrig, strapCfg;
  logic [3:0]       regAddr;
  logic [15:0]      regWrData, regRdData, rdV;
  logic [NPAIR-1:0] pairOutH, pairOutL, pairOeH, pairOeL;
  int               hiCnt, loCnt, bothCnt, trigCnt, err_total, comparisons, ones, mx;
  mcp_pwm #(.NPAIR(NPAIR)) uut (.mclk, .rst, .cpuIdle, .outEnableResetCfg(strapCfg), .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .pairOutH, .pairOutL, .pairOeH, .pairOeL,
    .specialEventTrig);
  mcp_switch_model #(.NPAIR(NPAIR)) sw (.mclk, .clr, .pairOutH, .pairOutL, .pairOeH,
    .pairOeL, .specialEventTrig, .hiCnt, .loCnt, .bothCnt, .trigCnt);
  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // tallies drift by a cycle or two with pipeline phase, hence ranges
  task automatic rng(input string n, input int lo, input int hi, input logic signed [31:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_total++;
      $display("Error %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic run(input int n);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the roughly 4600 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    cpuIdle = 1'b0;
    strapCfg = 1'b1;
    clr = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    err_total = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("strap enables", 16'h0007, {13'h0000, pairOeH});
    foreach (RA[i]) begin
      rd(RA[i], rdV);
      chk("reset value", 16'h0000, rdV);
    end
    foreach (MA[i]) begin
      wr(MA[i], 16'hFFFF);
      rd(MA[i], rdV);
      chk("write mask", ME[i], rdV);
      wr(MA[i], 16'h0000);
    end
    rd(4'hF, rdV);
    chk("unmapped", 16'h0000, rdV);
    // count rate per prescale, and idle with and without idle stop
    wr(4'h2, 16'h7FFF);
    foreach (PC[i]) begin
      cpuIdle <= (i >= 4);
      wr(4'h1, 16'h0000);
      wr(4'h0, PC[i]);
      repeat (255) @(posedge mclk);
      wr(4'h0, 16'h0000);
      rd(4'h1, rdV);
      rng("count rate", PE[i] - 2, PE[i] + 2, {16'h0000, rdV});
    end
    cpuIdle <= 1'b0;
    // every count mode: peak, direction flag, single pulse end
    wr(4'h2, 16'h000A);
    for (int m = 0; m < 4; m++) begin
      wr(4'h1, 16'h0000);
      wr(4'h0, 16'h8000 | 16'(m));
      ones = 0;
      mx = 0;
      repeat (30) begin
        rd(4'h1, rdV);
        ones += int'(rdV[15]);
        if (int'(rdV[14:0]) > mx) mx = int'(rdV[14:0]);
      end
      rng("peak count", 8, 10, mx);
      rng("down reads", (m > 1) ? 5 : 0, (m > 1) ? 25 : 0, ones);
      rd(4'h0, rdV);
      chk("on bit", (m == 1) ? 16'h0000 : 16'h0001, {15'h0000, rdV[15]});
      wr(4'h0, 16'h0000);
    end
    // special event trigger by compare, direction and postscale
    wr(4'h2, 16'h0009);
    foreach (TS[i]) begin
      wr(4'h1, 16'h0000);
      wr(4'h3, TS[i]);
      wr(4'h5, TU[i]);
      wr(4'h0, (i == 4) ? 16'h8002 : 16'h8000);
      run(200);
      rng("trigger count", TE[i] - 1, TE[i] + 1, trigCnt);
      wr(4'h0, 16'h0000);
    end
    // pins: dead time from either unit, then duty buffering
    wr(4'h5, 16'h0000);
    wr(4'h4, 16'h0077);
    wr(4'h9, 16'h0005);
    wr(4'h0, 16'h8000);
    foreach (PD[i]) begin
      wr(4'h6, PD[i]);
      wr(4'h7, (i == 1) ? 16'h0003 : 16'h0000);
      run(200);
      rng("conduction", ES[i] - 10, ES[i] + 10, hiCnt + loCnt);
      rng("overlap", 0, 0, bothCnt);
    end
    wr(4'h5, 16'h0001);
    wr(4'h9, 16'h0008);
    run(200);
    rng("frozen duty", 94, 106, hiCnt);
    wr(4'h5, 16'h0000);
    run(200);
    rng("new duty", 154, 166, hiCnt);
    wr(4'h5, 16'h0004);
    wr(4'h9, 16'h0002);
    run(200);
    rng("immediate duty", 34, 46, hiCnt);
    wr(4'h4, 16'h0177);
    run(200);
    rng("independent overlap", 30, 50, bothCnt);
    // pair 0 high pin taken over and driven high, applied on the next cycle
    wr(4'h8, 16'h3D02);
    run(200);
    rng("override high", 198, 200, hiCnt);
    wr(4'h8, 16'h3F00);
    wr(4'h4, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk("enables off", 16'h0000, {10'h000, pairOeH, pairOeL});
    // second reset with the strap low: enables must follow the strap, not a fixed value
    @(posedge mclk);
    strapCfg <= 1'b0;
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("strap low enables", 16'h0000, {10'h000, pairOeH, pairOeL});
    end_of_test;
  end
endmodule // mcp_pwm_tb_top
bind mcp_pwm mcp_pwm_chk #(.NPAIR(NPAIR)) chk (.mclk, .rst, .cpuIdle, .outEnableResetCfg,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pairOutH, .pairOutL, .pairOeH,
  .pairOeL, .specialEventTrig);
